// ---- core/status_pkg.sv ----
/*
 * Shared constants for the serial error and device health register bank:
 * register offsets, reset values, bit positions, check-enable codes,
 * cross-domain event indices and the power-on init state type.
 * Assumes an 8-bit register space with 7-bit addresses.
 */
package status_pkg;
	// ----------------------------------------------------------------
	// register space
	// ----------------------------------------------------------------
	localparam int             ADDR_W             = 7;
	localparam int             DATA_W             = 8;
	localparam logic [6:0]     ADDR_SERIAL_STATUS = 7'h11;
	localparam logic [6:0]     ADDR_OUTPUT_ROUTE  = 7'h14;
	localparam logic [6:0]     ADDR_HEALTH        = 7'h20;
	localparam logic [7:0]     SERIAL_STATUS_RST  = 8'h00;
	localparam logic [7:0]     OUTPUT_ROUTE_RST   = 8'h00;
	localparam logic [7:0]     HEALTH_RST         = 8'h40;
	localparam logic [7:0]     READ_ZERO          = 8'h00;
	// serial error status bits
	localparam int             SS_NOT_READY       = 7;
	localparam int             SS_EDGE_COUNT      = 4;
	localparam int             SS_CHECKSUM        = 3;
	localparam int             SS_RO_WRITE        = 2;
	localparam int             SS_BAD_ADDR        = 0;
	// output route bit
	localparam int             RT_LANE_ZERO       = 0;
	// device health bits
	localparam int             HS_READY           = 7;
	localparam int             HS_RESET           = 6;
	localparam int             HS_FUSE            = 5;
	localparam int             HS_REGMAP          = 4;
	localparam int             HS_SERIAL          = 3;
	localparam int             HS_RANGE           = 2;
	localparam int             HS_PDOWN           = 1;
	localparam int             HS_SLEEP           = 0;
	// ----------------------------------------------------------------
	// serial checksum enable codes and register map check span
	// ----------------------------------------------------------------
	localparam logic [1:0]     CHK_EN_ON          = 2'h1;
	localparam logic [1:0]     CHK_EN_N_ON        = 2'h2;
	localparam logic [6:0]     REGMAP_FIRST       = 7'h25;
	localparam logic [6:0]     REGMAP_LAST        = 7'h71;
	localparam logic [15:0]    REGMAP_INIT        = 16'hFFFF;
	// ----------------------------------------------------------------
	// write-one-to-clear flag slots and their reset values
	// ----------------------------------------------------------------
	localparam int             F_BAD_ADDR         = 0;
	localparam int             F_RO_WRITE         = 1;
	localparam int             F_CHECKSUM         = 2;
	localparam int             F_NOT_READY        = 3;
	localparam int             F_REGMAP           = 4;
	localparam int             F_FUSE             = 5;
	localparam int             F_RESET            = 6;
	localparam int             F_COUNT            = 7;
	localparam logic [6:0]     F_RST              = 7'h40;
	// link-domain event slots
	localparam int             EV_FRAME_START     = 0;
	localparam int             EV_EDGE_COUNT      = 1;
	localparam int             EV_CHECKSUM        = 2;
	localparam int             EV_RO_WRITE        = 3;
	localparam int             EV_BAD_ADDR        = 4;
	localparam int             EV_COUNT           = 5;
	// power-on initialisation progress
	typedef enum logic [1:0] {
		ST_BOOT  = 2'b00,
		ST_READY = 2'b01,
		ST_FAULT = 2'b10
	} init_state_t;
endpackage : status_pkg

// ---- core/link_event_if.sv ----
/*
 * Carrier for single-cycle events raised on the serial link clock and
 * delivered as single-cycle pulses on the system clock.
 * Assumes the producer drives link_pulse on the link clock.
 */
interface link_event_if #(parameter int N = 1) ();
	logic [N-1:0] link_pulse;  // raised on the link clock
	logic [N-1:0] sys_pulse;   // delivered on the system clock
	modport producer (output link_pulse, input sys_pulse);
	modport crosser  (input link_pulse, output sys_pulse);
endinterface : link_event_if

// ---- core/event_sync.sv ----
/*
 * Toggle crossing of N event pulses from the link clock to CLK.
 * Assumes two events on one slot are at least three CLK periods apart;
 * closer ones fold together, since a toggle pair cancels.
 */
module event_sync #(
	parameter int N = 1
) (
	input  wire logic      clk,
	input  wire logic      nrst,
	input  wire logic      link_clk,
	input  wire logic      link_nrst,
	link_event_if.crosser  ev
);
	logic [N-1:0] tog_q;  // link side toggles
	logic [N-1:0] s1_q;   // first stage, read by s2_q only
	logic [N-1:0] s2_q;   // second stage
	logic [N-1:0] s3_q;   // edge reference

	// ----------------------------------------------------------------
	// link side: flip a toggle per event
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk) begin
		if (!link_nrst) tog_q <= '0;
		else            tog_q <= tog_q ^ ev.link_pulse;
	end

	// ----------------------------------------------------------------
	// system side: two-stage sync then edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= tog_q;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign ev.sys_pulse = s2_q ^ s3_q;
endmodule : event_sync

// ---- core/flag_cell.sv ----
/*
 * One sticky write-one-to-clear status flag with a chosen reset value.
 * Assumes set and clear are single-clock-domain strobes on clk.
 */
module flag_cell #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	// ----------------------------------------------------------------
	// set beats clear so a coincident event is never lost
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst)    q <= RST_VAL;
		else if (set) q <= 1'b1;  // RULE19
		else if (clr) q <= 1'b0;  // RULE19
	end

	property p_set_wins;
		@(posedge clk) disable iff (!nrst) set |=> q;
	endproperty
	a_set_wins: assert property (p_set_wins) // RULE19
		else $error("flag lost a set event");

	property p_zero_keeps;
		@(posedge clk) disable iff (!nrst)
			(!set && !clr) |=> (q == $past(q));
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) // RULE19
		else $error("flag changed without set or clear");
endmodule : flag_cell

// ---- core/serial_status_regs.sv ----
/*
 * Serial error status, output route and device health registers.
 * Link events arrive on the serial clock and cross by toggles; health
 * sources and the register access port run on CLK. Assumes the serial
 * engine decodes frames and raises one-clock event pulses on its clock.
 */
// Functional notes
// RULE1: early transaction sets not-ready flag, W1C
// RULE2: bad edge count sets plain read/write bit
// RULE3: checksum mismatch while enabled sets flag, W1C
// RULE4: write to read-only register sets flag
// RULE5: undefined address access sets flag, W1C
// RULE6: serial status at 0x11, reserved zero
// RULE7: route bit picks config out or lane
// RULE8: ready set at busy fall, fault clears
// RULE9: reset flag set by reset, W1C
// RULE10: fuse corruption sets flag, W1C
// RULE11: register map mismatch sets flag, W1C
// RULE12: serial summary is OR of status
// RULE13: range summary ORs over/under status
// RULE14: powered-down bit follows power-down mode
// RULE15: sleep summary ORs channel sleep bits
// RULE16: health at 0x20, resets to 0x40
// RULE17: checking only when fields are 1/2
// RULE18: map check spans 0x71..0x25, seed FFFF
// RULE19: zero write keeps; set beats clear
// RULE20: read-only bits ignore writes
module serial_status_regs
	import status_pkg::*;
#(
	parameter int CH_N = 4
) (
	input  wire logic              CLK,
	input  wire logic              NRST,
	input  wire logic              CONFIG_SERIAL_CLOCK,
	input  wire logic              BUSY,
	input  wire logic              INTERNAL_FAULT,
	input  wire logic              FUSE_MISMATCH,
	input  wire logic              REGMAP_MISMATCH,
	input  wire logic              RESET_EVENT,
	input  wire logic              POWER_DOWN,
	input  wire logic [CH_N-1:0]   RANGE_OVER,
	input  wire logic [CH_N-1:0]   RANGE_UNDER,
	input  wire logic [CH_N-1:0]   CHANNEL_SLEEP,
	input  wire logic [1:0]        CHECK_ENABLE,
	input  wire logic [1:0]        CHECK_ENABLE_N,
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	input  wire logic              FRAME_START,
	input  wire logic              EDGE_COUNT_BAD,
	input  wire logic              CHECKSUM_BAD,
	input  wire logic              RO_WRITE_TRY,
	input  wire logic              ADDR_UNDEFINED,
	input  wire logic              CONFIG_READ_BIT,
	input  wire logic              CONVERSION_BIT,
	output logic                   CONFIG_SERIAL_OUT,
	output logic                   CONVERSION_LANE_ZERO
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (CH_N < 1 || CH_N > 8) begin : g_bad_ch
		$error("CH_N must lie in 1..8");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic              lrst1_q;       // link reset stage one
	logic              lrst2_q;       // link reset, synchronous
	logic              lane1_q;       // route bit, first link stage
	logic              lane2_q;       // route bit, synced to link
	logic              cfg_out_q;     // dedicated config output
	logic              lane0_q;       // conversion lane zero
	logic              busy1_q;       // busy pin, first stage
	logic              busy2_q;       // busy pin, synced
	logic              busy3_q;       // busy, edge reference
	init_state_t       init_q;        // power-on progress
	init_state_t       init_d;
	logic              edge_q;        // edge count error bit
	logic              edge_d;
	logic              route_q;       // lane select bit
	logic              route_d;
	logic [DATA_W-1:0] rdata_q;       // registered read data
	logic [DATA_W-1:0] rdata_d;
	logic [F_COUNT-1:0] flag_q;       // sticky w1c flags
	logic [F_COUNT-1:0] flag_set;
	logic [F_COUNT-1:0] flag_clr;
	logic [DATA_W-1:0] serial_status; // assembled 0x11 view
	logic [DATA_W-1:0] health_status; // assembled 0x20 view
	logic [DATA_W-1:0] route_status;  // assembled 0x14 view

	link_event_if #(.N(EV_COUNT)) ev ();

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire hit_serial = (REG_ADDR == ADDR_SERIAL_STATUS);
	wire hit_route  = (REG_ADDR == ADDR_OUTPUT_ROUTE);
	wire hit_health = (REG_ADDR == ADDR_HEALTH); // RULE16
	wire wr_serial  = REG_WR && hit_serial;
	wire wr_route   = REG_WR && hit_route;
	wire wr_health  = REG_WR && hit_health;
	wire busy_fall  = busy3_q && !busy2_q;
	wire dev_ready  = (init_q == ST_READY);
	// checking armed only for the exact code pair
	wire chk_active = (CHECK_ENABLE == CHK_EN_ON) &&
	                  (CHECK_ENABLE_N == CHK_EN_N_ON); // RULE17
	wire ev_frame   = ev.sys_pulse[EV_FRAME_START];
	wire ev_edge    = ev.sys_pulse[EV_EDGE_COUNT];
	wire ev_chk     = ev.sys_pulse[EV_CHECKSUM];
	wire ev_ro      = ev.sys_pulse[EV_RO_WRITE];
	wire ev_addr    = ev.sys_pulse[EV_BAD_ADDR];
	wire range_any  = |{RANGE_OVER, RANGE_UNDER}; // RULE13
	wire sleep_any  = |CHANNEL_SLEEP; // RULE15

	// ----------------------------------------------------------------
	// link clock domain: reset sync, route sync, output lanes
	// ----------------------------------------------------------------
	// the link clock only runs in frames, so its reset lags NRST
	always_ff @(posedge CONFIG_SERIAL_CLOCK) begin
		lrst1_q <= NRST;
		lrst2_q <= lrst1_q;
	end

	// route bit is quasi-static, a level sync is enough
	always_ff @(posedge CONFIG_SERIAL_CLOCK) begin
		if (!lrst2_q) begin
			lane1_q <= 1'b0;
			lane2_q <= 1'b0;
		end else begin
			lane1_q <= route_q;
			lane2_q <= lane1_q;
		end
	end

	// read data steered onto one lane; an idle lane zero carries CONVERSION_BIT, an idle config output drives 0
	always_ff @(posedge CONFIG_SERIAL_CLOCK) begin
		if (!lrst2_q) begin
			cfg_out_q <= 1'b0;
			lane0_q   <= 1'b0;
		end else begin
			cfg_out_q <= lane2_q ? 1'b0 : CONFIG_READ_BIT; // RULE7
			lane0_q   <= lane2_q ? CONFIG_READ_BIT
			                     : CONVERSION_BIT; // RULE7
		end
	end

	assign CONFIG_SERIAL_OUT    = cfg_out_q;
	assign CONVERSION_LANE_ZERO = lane0_q;

	// serial engine events, same link clock, no sync needed here
	assign ev.link_pulse = {ADDR_UNDEFINED, RO_WRITE_TRY, CHECKSUM_BAD,
	                        EDGE_COUNT_BAD, FRAME_START};

	event_sync #(.N(EV_COUNT)) u_event_sync (
		.clk       (CLK),
		.nrst      (NRST),
		.link_clk  (CONFIG_SERIAL_CLOCK),
		.link_nrst (lrst2_q),
		.ev        (ev)
	);

	// ----------------------------------------------------------------
	// busy pin sync and power-on progress
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			busy1_q <= 1'b0;
			busy2_q <= 1'b0;
			busy3_q <= 1'b0;
		end else begin
			busy1_q <= BUSY;
			busy2_q <= busy1_q;
			busy3_q <= busy2_q;
		end
	end

	// only the first busy fall ends init; a fault needs global reset
	always_comb begin
		init_d = init_q;
		case (init_q)
			ST_BOOT: begin
				if (busy_fall) init_d = ST_READY; // RULE8
			end
			ST_READY: begin
				if (INTERNAL_FAULT) init_d = ST_FAULT; // RULE8
			end
			ST_FAULT: begin
				init_d = ST_FAULT;
			end
			default: begin
				init_d = ST_FAULT;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// sticky flag sources and clears
	// ----------------------------------------------------------------
	always_comb begin
		flag_set              = '0;
		flag_set[F_BAD_ADDR]  = ev_addr; // RULE5
		flag_set[F_RO_WRITE]  = ev_ro; // RULE4
		flag_set[F_CHECKSUM]  = ev_chk && chk_active; // RULE3
		flag_set[F_NOT_READY] = ev_frame && !dev_ready; // RULE1
		flag_set[F_REGMAP]    = REGMAP_MISMATCH; // RULE11 RULE18
		flag_set[F_FUSE]      = FUSE_MISMATCH; // RULE10
		flag_set[F_RESET]     = RESET_EVENT; // RULE9
		flag_clr              = '0;
		flag_clr[F_BAD_ADDR]  = wr_serial && REG_WDATA[SS_BAD_ADDR];
		flag_clr[F_RO_WRITE]  = wr_serial && REG_WDATA[SS_RO_WRITE];
		flag_clr[F_CHECKSUM]  = wr_serial && REG_WDATA[SS_CHECKSUM];
		flag_clr[F_NOT_READY] = wr_serial && REG_WDATA[SS_NOT_READY];
		flag_clr[F_REGMAP]    = wr_health && REG_WDATA[HS_REGMAP];
		flag_clr[F_FUSE]      = wr_health && REG_WDATA[HS_FUSE];
		flag_clr[F_RESET]     = wr_health && REG_WDATA[HS_RESET];
	end

	for (genvar i = 0; i < F_COUNT; i++) begin : g_flag
		flag_cell #(.RST_VAL(F_RST[i])) u_flag (
			.clk  (CLK),
			.nrst (NRST),
			.set  (flag_set[i]),
			.clr  (flag_clr[i]),
			.q    (flag_q[i])
		);
	end

	// edge count bit: plain read/write, but an event still wins
	assign edge_d  = ev_edge ? 1'b1 :
	                 wr_serial ? REG_WDATA[SS_EDGE_COUNT] : edge_q; // RULE2
	assign route_d = wr_route ? REG_WDATA[RT_LANE_ZERO] : route_q;

	// ----------------------------------------------------------------
	// register views; reserved and read-only bits are not stored
	// ----------------------------------------------------------------
	always_comb begin
		serial_status                = SERIAL_STATUS_RST; // RULE6
		serial_status[SS_NOT_READY]  = flag_q[F_NOT_READY];
		serial_status[SS_EDGE_COUNT] = edge_q;
		serial_status[SS_CHECKSUM]   = flag_q[F_CHECKSUM];
		serial_status[SS_RO_WRITE]   = flag_q[F_RO_WRITE];
		serial_status[SS_BAD_ADDR]   = flag_q[F_BAD_ADDR];
		route_status                 = OUTPUT_ROUTE_RST;
		route_status[RT_LANE_ZERO]   = route_q;
		health_status                = READ_ZERO;
		health_status[HS_READY]      = dev_ready; // RULE8 RULE20
		health_status[HS_RESET]      = flag_q[F_RESET];
		health_status[HS_FUSE]       = flag_q[F_FUSE];
		health_status[HS_REGMAP]     = flag_q[F_REGMAP];
		health_status[HS_SERIAL]     = |serial_status; // RULE12
		health_status[HS_RANGE]      = range_any;
		health_status[HS_PDOWN]      = POWER_DOWN; // RULE14
		health_status[HS_SLEEP]      = sleep_any;
	end

	// unmapped reads return zero; the engine flags the bad address
	assign rdata_d = !REG_RD    ? rdata_q :
	                 hit_serial ? serial_status :
	                 hit_route  ? route_status :
	                 hit_health ? health_status : READ_ZERO;

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			init_q  <= ST_BOOT;
			edge_q  <= SERIAL_STATUS_RST[SS_EDGE_COUNT];
			route_q <= OUTPUT_ROUTE_RST[RT_LANE_ZERO];
			rdata_q <= READ_ZERO;
		end else begin
			init_q  <= init_d;
			edge_q  <= edge_d;
			route_q <= route_d;
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_not_ready;
		@(posedge CLK) disable iff (!NRST)
			(ev_frame && !dev_ready) |=> serial_status[SS_NOT_READY];
	endproperty
	a_not_ready: assert property (p_not_ready) // RULE1
		else $error("early frame did not raise not-ready");

	property p_edge_rw;
		@(posedge CLK) disable iff (!NRST)
			(wr_serial && !ev_edge) |=>
			edge_q == $past(REG_WDATA[SS_EDGE_COUNT]);
	endproperty
	a_edge_rw: assert property (p_edge_rw) // RULE2
		else $error("edge count bit did not take written value");

	property p_chk_gate;
		@(posedge CLK) disable iff (!NRST)
			$rose(flag_q[F_CHECKSUM]) |->
			$past(ev_chk) && $past(chk_active);
	endproperty
	a_chk_gate: assert property (p_chk_gate) // RULE3
		else $error("checksum flag rose while checking off");

	property p_ro_set;
		@(posedge CLK) disable iff (!NRST)
			ev_ro ##1 !flag_clr[F_RO_WRITE] |-> flag_q[F_RO_WRITE] [*2];
	endproperty
	a_ro_set: assert property (p_ro_set) // RULE4
		else $error("read-only write flag not held");

	property p_rsvd_zero;
		@(posedge CLK) disable iff (!NRST)
			(REG_RD && hit_serial) |=>
			(REG_RDATA[6:5] == 2'b00) && !REG_RDATA[1];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // RULE6
		else $error("reserved serial status bits not zero");

	property p_route_lane;
		@(posedge CONFIG_SERIAL_CLOCK) disable iff (!lrst2_q)
			lane2_q |=> !cfg_out_q;
	endproperty
	a_route_lane: assert property (p_route_lane) // RULE7
		else $error("config output active while routed to lane");

	property p_ready_cause;
		@(posedge CLK) disable iff (!NRST)
			$rose(dev_ready) |-> $past(busy_fall);
	endproperty
	a_ready_cause: assert property (p_ready_cause) // RULE8
		else $error("ready without busy falling edge");

	property p_summary;
		@(posedge CLK) disable iff (!NRST)
			(REG_RD && hit_health) |=>
			REG_RDATA[HS_SERIAL] == (|$past(serial_status));
	endproperty
	a_summary: assert property (p_summary) // RULE12
		else $error("serial summary differs from status OR");

	property p_health_reset;
		@(posedge CLK)
			$rose(NRST) |-> flag_q[F_RESET] && !dev_ready;
	endproperty
	a_health_reset: assert property (p_health_reset) // RULE16
		else $error("health register not at reset value");

	property p_ready_kept;
		@(posedge CLK) disable iff (!NRST)
			(wr_health && !INTERNAL_FAULT && !busy_fall) |=>
			dev_ready == $past(dev_ready);
	endproperty
	a_ready_kept: assert property (p_ready_kept) // RULE20
		else $error("write changed read-only ready bit");

	c_boot_ready: cover property (@(posedge CLK) disable iff (!NRST)
		init_q == ST_BOOT ##1 init_q == ST_READY);
	c_fault: cover property (@(posedge CLK) disable iff (!NRST)
		init_q == ST_FAULT);
	c_set_clr: cover property (@(posedge CLK) disable iff (!NRST)
		flag_set[F_CHECKSUM] && flag_clr[F_CHECKSUM]);
	c_lane: cover property (@(posedge CONFIG_SERIAL_CLOCK)
		disable iff (!lrst2_q) lane2_q);
endmodule : serial_status_regs

// ---- sim/link_host_model.sv ----
/* link-side host model: serial config clock and event strobes.
   assumes the bench calls frame() while no other frame runs. */
module link_host_model (
	output logic       sck, // stands low between frames
	output logic [4:0] ev   // one-cycle strobes, EV_* slot order
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------
	initial begin
		sck = 1'b0;
		ev  = 5'h00;
	end
	// frame of n link cycles; strobes sampled on its first edge
	// odd start offset keeps link edges off the system grid
	task automatic frame(input logic [4:0] e, input int n);
		#7;
		ev = e;
		for (int i = 0; i < n; i++) begin
			#15 sck = 1'b1;
			#15 sck = 1'b0;
			ev = 5'h00;
		end
	endtask : frame
endmodule : link_host_model

// ---- sim/serial_status_regs_bench.sv ----
/* self-checking bench for the serial error and health registers.
   assumes the design checks itself with its own assertions. */
module serial_status_regs_bench;
	import status_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// stimulus and observation
	// ------------------------------------------------------------
	logic              CLK, NRST, BUSY, INTERNAL_FAULT, FUSE_MISMATCH;
	logic              REGMAP_MISMATCH, RESET_EVENT, POWER_DOWN;
	logic              REG_WR, REG_RD, CONFIG_READ_BIT, CONVERSION_BIT;
	logic              CONFIG_SERIAL_OUT, CONVERSION_LANE_ZERO, sck, rd_d;
	logic [3:0]        RANGE_OVER, RANGE_UNDER, CHANNEL_SLEEP;
	logic [1:0]        CHECK_ENABLE, CHECK_ENABLE_N;
	logic [ADDR_W-1:0] REG_ADDR;
	logic [DATA_W-1:0] REG_WDATA, REG_RDATA, hs;
	logic [4:0]        ev;
	logic [7:0]        exp_q[$]; // expected read bytes, oldest first
	int errors = 0, checks_done = 0, cyc = 0, seed = 32'hA6BABF12;

	serial_status_regs #(.CH_N(4)) i_dut (.*, .CONFIG_SERIAL_CLOCK(sck),
		.FRAME_START(ev[EV_FRAME_START]), .EDGE_COUNT_BAD(ev[EV_EDGE_COUNT]),
		.CHECKSUM_BAD(ev[EV_CHECKSUM]), .RO_WRITE_TRY(ev[EV_RO_WRITE]),
		.ADDR_UNDEFINED(ev[EV_BAD_ADDR]));
	link_host_model i_host (.sck(sck), .ev(ev));

	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge CLK);
		REG_ADDR  = a;
		REG_WDATA = d;
		REG_WR    = 1'b1;
		@(negedge CLK);
		REG_WR = 1'b0;
	endtask : wr
	// read request; expectation queued for the monitor
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(negedge CLK);
		REG_ADDR = a;
		REG_RD   = 1'b1;
		exp_q.push_back(e);
		@(negedge CLK);
		REG_RD = 1'b0;
	endtask : rd
	// frame then settle: crossing lands within 5 clocks
	task automatic lf(input logic [4:0] e);
		i_host.frame(e, 5);
		repeat (8) @(negedge CLK);
	endtask : lf
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// monitor and watchdog
	// ------------------------------------------------------------
	always @(posedge CLK) rd_d <= REG_RD & NRST;
	always @(negedge CLK) begin
		if (rd_d)
			chk("rdata", exp_q.pop_front(), REG_RDATA);
	end
	// whole run is about 200 clocks; far margin before calling a hang
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{NRST, BUSY, INTERNAL_FAULT, FUSE_MISMATCH} = 4'h4;
		{REGMAP_MISMATCH, RESET_EVENT, POWER_DOWN, REG_WR, REG_RD} = 5'h00;
		{CONFIG_READ_BIT, CONVERSION_BIT} = 2'h0;
		{RANGE_OVER, RANGE_UNDER, CHANNEL_SLEEP} = 12'h000;
		CHECK_ENABLE   = 2'h0;
		CHECK_ENABLE_N = 2'h3;
		REG_ADDR  = 7'h00;
		REG_WDATA = 8'h00;
		// link side needs edges during reset to take it
		i_host.frame(5'h00, 4);
		repeat (2) @(negedge CLK);
		NRST = 1'b1;
		// link reset lags release by two link edges
		i_host.frame(5'h00, 2);
		rd(ADDR_SERIAL_STATUS, 8'h00);
		rd(ADDR_OUTPUT_ROUTE, 8'h00);
		rd(ADDR_HEALTH, 8'h40);
		rd(7'h30, 8'h00);
		wr(ADDR_HEALTH, 8'hBF);
		rd(ADDR_HEALTH, 8'h40);
		wr(ADDR_HEALTH, 8'h40);
		rd(ADDR_HEALTH, 8'h00);
		$display("reset test done");
		lf(5'h01);
		rd(ADDR_SERIAL_STATUS, 8'h80);
		rd(ADDR_HEALTH, 8'h08);
		wr(ADDR_SERIAL_STATUS, 8'h6F);
		rd(ADDR_SERIAL_STATUS, 8'h80);
		wr(ADDR_SERIAL_STATUS, 8'h80);
		rd(ADDR_SERIAL_STATUS, 8'h00);
		BUSY = 1'b0;
		repeat (4) @(negedge CLK);
		rd(ADDR_HEALTH, 8'h80);
		lf(5'h01);
		rd(ADDR_SERIAL_STATUS, 8'h00);
		$display("ready test done");
		// checking stays off: inverted field still 0x3
		CHECK_ENABLE = 2'h1;
		lf(5'h1E);
		rd(ADDR_SERIAL_STATUS, 8'h15);
		CHECK_ENABLE_N = 2'h2;
		lf(5'h04);
		rd(ADDR_SERIAL_STATUS, 8'h1D);
		rd(ADDR_HEALTH, 8'h88);
		wr(ADDR_SERIAL_STATUS, 8'hFF);
		rd(ADDR_SERIAL_STATUS, 8'h10);
		wr(ADDR_SERIAL_STATUS, 8'h00);
		rd(ADDR_SERIAL_STATUS, 8'h00);
		$display("serial error test done");
		for (int i = 0; i < 8; i++) begin
			{RANGE_OVER, RANGE_UNDER, CHANNEL_SLEEP} = 12'($random(seed));
			POWER_DOWN = 1'($random(seed));
			{FUSE_MISMATCH, REGMAP_MISMATCH, RESET_EVENT} = 3'($random(seed));
			hs = {1'b1, RESET_EVENT, FUSE_MISMATCH, REGMAP_MISMATCH, 1'b0,
				|{RANGE_OVER, RANGE_UNDER}, POWER_DOWN, |CHANNEL_SLEEP};
			@(negedge CLK);
			{FUSE_MISMATCH, REGMAP_MISMATCH, RESET_EVENT} = 3'h0;
			rd(ADDR_HEALTH, hs);
			wr(ADDR_HEALTH, 8'h70);
		end
		$display("health test done");
		INTERNAL_FAULT = 1'b1;
		@(negedge CLK);
		INTERNAL_FAULT = 1'b0;
		repeat (2) @(negedge CLK);
		rd(ADDR_HEALTH, {5'h00, hs[2:0]});
		lf(5'h01);
		rd(ADDR_SERIAL_STATUS, 8'h80);
		$display("fault test done");
		for (int r = 0; r < 2; r++) begin
			wr(ADDR_OUTPUT_ROUTE, r[0] ? 8'hFF : 8'hFE);
			rd(ADDR_OUTPUT_ROUTE, {7'h00, r[0]});
			{CONFIG_READ_BIT, CONVERSION_BIT} = 2'($random(seed));
			lf(5'h00);
			chk("cfg_out", {7'h00, CONFIG_READ_BIT & ~r[0]},
				{7'h00, CONFIG_SERIAL_OUT});
			chk("lane0", {7'h00, r[0] ? CONFIG_READ_BIT : CONVERSION_BIT},
				{7'h00, CONVERSION_LANE_ZERO});
		end
		$display("route test done");
		give_verdict();
	end
endmodule : serial_status_regs_bench
